// ===== hdl/hdc_defs.svh
`ifndef HDC_DEFS_SVH
`define HDC_DEFS_SVH

// ==========================================================
// Register map (printed indices; byte address = index * 4)
// ==========================================================
`define HDC_IDX_CTL1      8'h1B
`define HDC_IDX_CTL2      8'h1C
`define HDC_IDX_STAT      8'h1D
`define HDC_ADDR_W        10

// ==========================================================
// Field positions and reset values
// ==========================================================
`define HDC_BIT_BOOST     7
`define HDC_BIT_RSVD      6
`define HDC_BIT_CMBIAS    5
`define HDC_DT_MSB        4
`define HDC_CTL1_RST      8'h93
`define HDC_CTL1_WMASK    8'hBF
`define HDC_CTL2_RST      8'hF5

// ==========================================================
// Timing (times in ns, clock 4 ns)
// ==========================================================
`define HDC_CLK_NS        4
`define HDC_LRA_STEP_NS   100_000
`define HDC_LRA_OFS_NS    500_000
`define HDC_ERM_STEP_NS   200_000
`define HDC_ERM_OFS_NS    1_000_000
`define HDC_PER_W         21
`define HDC_PER_MIN       21'h0_0002

`endif

// ===== hdl/hdc_pkg.sv
`default_nettype none

// ==========================================================
// Types shared by the drive control block
// ==========================================================
package hdc_pkg;

   // Layout of the first drive control register
   typedef struct packed {
      logic       boost;
      logic       rsvd;
      logic       cm_bias;
      logic [4:0] drive_time;
   } hdc_ctl1_t;

   // Synchronised view of the inputs from outside the clock
   typedef struct packed {
      logic lra_mode;
      logic zero_cross;
   } hdc_ext_t;

endpackage

`default_nettype wire

// ===== hdl/hdc_drive_ctrl.sv
// Notes on behaviour
// - boost bit 7, reset 1, raises loop gain while overdrive is active.
// - common-mode bit 5 set drives bias onto the input/trigger pin.
// - common-mode bit 0 (reset) leaves the input/trigger pin unbiased.
// - drive-time field bits 4..0, reset 0x13, meaning depends on mode.
// - resonant mode drive time is field times 0.1 ms plus 0.5 ms.
// - resonant mode treats programmed time as estimate, then tracks.
// - rotating-mass sampling interval is field times 0.2 ms plus 1 ms.
//
// The APB slave port was decided locally.
`include "hdc_defs.svh"
`default_nettype none

module hdc_drive_ctrl
   import hdc_pkg::*;
#(
   parameter int LRA_STEP_CYC = `HDC_LRA_STEP_NS / `HDC_CLK_NS,
   parameter int LRA_OFS_CYC  = `HDC_LRA_OFS_NS / `HDC_CLK_NS,
   parameter int ERM_STEP_CYC = `HDC_ERM_STEP_NS / `HDC_CLK_NS,
   parameter int ERM_OFS_CYC  = `HDC_ERM_OFS_NS / `HDC_CLK_NS
) (
   // Clock and reset
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   // APB slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [`HDC_ADDR_W-1:0] paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   // Actuator mode and feedback (asynchronous pins)
   input  wire logic                   lra_mode_pin,
   input  wire logic                   zero_cross_pin,
   // Overdrive phase from the drive engine
   input  wire logic                   overdrive_active,
   // Loop and pin controls
   output logic                        overdrive_gain_boost,
   output logic                        input_common_mode_bias,
   // Drive timing
   output logic                        drive_tick,
   output logic                        backemf_sample,
   output logic [`HDC_PER_W-1:0]       drive_period,
   // Second control register, passed to the engine
   output logic [7:0]                  drive_control_two_q
);

   // =======================================================
   // Declarations
   // =======================================================
   localparam logic [`HDC_PER_W-1:0] LRA_STEP = LRA_STEP_CYC[`HDC_PER_W-1:0];
   localparam logic [`HDC_PER_W-1:0] LRA_OFS  = LRA_OFS_CYC[`HDC_PER_W-1:0];
   localparam logic [`HDC_PER_W-1:0] ERM_STEP = ERM_STEP_CYC[`HDC_PER_W-1:0];
   localparam logic [`HDC_PER_W-1:0] ERM_OFS  = ERM_OFS_CYC[`HDC_PER_W-1:0];

   hdc_ctl1_t                 ctl1_r;
   logic [7:0]                ctl2_r;
   logic [31:0]               prdata_r;
   logic [2:0]                sync_r [2];
   hdc_ext_t                  ext_r;
   logic                      zc_prev_r;
   logic                      zc_event;
   logic                      mode_prev_r;
   logic                      mode_chg;
   logic [`HDC_PER_W-1:0]     prog_per;
   logic [`HDC_PER_W-1:0]     period_r;
   logic [`HDC_PER_W-1:0]     cnt_r;
   logic [`HDC_PER_W-1:0]     meas_r;
   logic                      seen_r;
   logic                      track_r;
   logic                      tick_r;
   logic                      sample_r;
   logic                      boost_r;
   logic                      cm_r;
   logic                      reload_r;
   logic                      setup;
   logic                      access;
   logic                      wr_ctl1;
   logic                      wr_ctl2;
   logic                      hit;
   logic [7:0]                idx;
   logic [1:0]                pin_in;

   // =======================================================
   // APB decode
   // =======================================================
   // Word index; low two address bits ignored
   assign idx    = paddr[`HDC_ADDR_W-1:2];
   assign setup  = psel & ~penable;
   assign access = psel & penable;
   assign hit    = (idx == `HDC_IDX_CTL1) | (idx == `HDC_IDX_CTL2) |
                   (idx == `HDC_IDX_STAT);
   assign wr_ctl1 = access & pwrite & (idx == `HDC_IDX_CTL1);
   assign wr_ctl2 = access & pwrite & (idx == `HDC_IDX_CTL2);

   // Zero wait states; unmapped access answers with an error
   assign pready  = 1'b1;
   assign pslverr = access & ~hit;
   assign prdata  = prdata_r;

   // =======================================================
   // Registers
   // =======================================================
   // First control register; reserved bit never stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl1_r <= `HDC_CTL1_RST;
      end else if (wr_ctl1) begin
         ctl1_r <= pwdata[7:0] & `HDC_CTL1_WMASK;
      end
   end

   // Second control register, held for the engine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl2_r <= `HDC_CTL2_RST;
      end else if (wr_ctl2) begin
         ctl2_r <= pwdata[7:0];
      end
   end
   assign drive_control_two_q = ctl2_r;

   // Read data captured in setup so it comes from a flip-flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         unique case (idx)
            `HDC_IDX_CTL1: begin
               prdata_r <= {24'h00_0000,
                            ctl1_r & `HDC_CTL1_WMASK};
            end
            `HDC_IDX_CTL2: begin
               prdata_r <= {24'h00_0000, ctl2_r};
            end
            `HDC_IDX_STAT: begin
               prdata_r <= {ext_r.lra_mode, track_r, 9'h000,
                            period_r};
            end
            default: begin
               prdata_r <= 32'h0000_0000;
            end
         endcase
      end
   end

   // =======================================================
   // Pin synchronisers
   // =======================================================
   // Three stages; a change counts once stages two and three agree
   assign pin_in = {lra_mode_pin, zero_cross_pin};

   generate
      for (genvar i = 0; i < 2; i++) begin : g_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sync_r[i] <= 3'h0;
            end else begin
               sync_r[i] <= {sync_r[i][1:0], pin_in[i]};
            end
         end
      end
   endgenerate

   // Filtered levels; stage one is read only by stage two
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_r <= '0;
      end else begin
         if (sync_r[1][1] == sync_r[1][2]) begin
            ext_r.lra_mode <= sync_r[1][2];
         end
         if (sync_r[0][1] == sync_r[0][2]) begin
            ext_r.zero_cross <= sync_r[0][2];
         end
      end
   end

   // Edge history for feedback crossings and mode changes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         zc_prev_r   <= 1'b0;
         mode_prev_r <= 1'b0;
      end else begin
         zc_prev_r   <= ext_r.zero_cross;
         mode_prev_r <= ext_r.lra_mode;
      end
   end
   // Both edges of the crossing signal mark a half period
   assign zc_event = ext_r.zero_cross ^ zc_prev_r;
   assign mode_chg = ext_r.lra_mode ^ mode_prev_r;

   // =======================================================
   // Loop gain boost and common-mode bias
   // =======================================================
   // Registered so the pin bias and gain step never glitch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boost_r <= 1'b0;
         cm_r    <= 1'b0;
      end else begin
         boost_r <= ctl1_r.boost & overdrive_active;
         cm_r    <= ctl1_r.cm_bias;
      end
   end
   assign overdrive_gain_boost   = boost_r;
   assign input_common_mode_bias = cm_r;

   // =======================================================
   // Programmed drive time
   // =======================================================
   // Step times field plus offset, chosen by actuator type
   always_comb begin
      if (ext_r.lra_mode) begin
         prog_per = `HDC_PER_W'(ctl1_r.drive_time * LRA_STEP)
                    + LRA_OFS;
      end else begin
         prog_per = `HDC_PER_W'(ctl1_r.drive_time * ERM_STEP)
                    + ERM_OFS;
      end
   end

   // Reload after a field write or a change of actuator type
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reload_r <= 1'b1;
      end else begin
         reload_r <= wr_ctl1 | mode_chg;
      end
   end

   // =======================================================
   // Resonance tracking
   // =======================================================
   // Measures cycles between feedback crossings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meas_r <= 21'h0_0000;
      end else if (zc_event) begin
         meas_r <= 21'h0_0001;
      end else if (meas_r != '1) begin
         meas_r <= meas_r + 21'h0_0001;
      end
   end

   // Two crossings needed before a measurement is trusted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen_r  <= 1'b0;
         track_r <= 1'b0;
      end else if (reload_r || !ext_r.lra_mode) begin
         seen_r  <= 1'b0;
         track_r <= 1'b0;
      end else if (zc_event) begin
         seen_r  <= 1'b1;
         track_r <= seen_r;
      end
   end

   // Active half period: estimate first, then measured value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_r <= 21'h0_0000;
      end else if (reload_r) begin
         period_r <= prog_per;
      end else if (ext_r.lra_mode && zc_event && seen_r &&
                   meas_r >= `HDC_PER_MIN) begin
         period_r <= meas_r;
      end else if (!ext_r.lra_mode) begin
         period_r <= prog_per;
      end
   end
   assign drive_period = period_r;

   // =======================================================
   // Drive and sampling timer
   // =======================================================
   // Restarts on reload so a new setting takes effect at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 21'h0_0000;
      end else if (reload_r || cnt_r + 21'h0_0001 >= period_r) begin
         cnt_r <= 21'h0_0000;
      end else begin
         cnt_r <= cnt_r + 21'h0_0001;
      end
   end

   // One-cycle pulses at the end of each interval
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_r   <= 1'b0;
         sample_r <= 1'b0;
      end else begin
         tick_r   <= ~reload_r & ext_r.lra_mode &
                     (cnt_r + 21'h0_0001 >= period_r);
         sample_r <= ~reload_r & ~ext_r.lra_mode &
                     (cnt_r + 21'h0_0001 >= period_r);
      end
   end
   assign drive_tick     = tick_r;
   assign backemf_sample = sample_r;

endmodule

`default_nettype wire

// ===== bench/hdc_drive_ctrl_assertions.sv
`include "hdc_defs.svh"
`default_nettype none

// ======
// Port checker
// ======
module hdc_drive_ctrl_assertions
   import hdc_pkg::*;
#(
   parameter int LRA_STEP_CYC = 4,
   parameter int LRA_OFS_CYC  = 10,
   parameter int ERM_STEP_CYC = 8,
   parameter int ERM_OFS_CYC  = 20
) (
   // Clock and reset
   input wire logic                   pclk,
   input wire logic                   presetn,
   // Bus
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [`HDC_ADDR_W-1:0] paddr,
   input wire logic [31:0]            pwdata,
   input wire logic [31:0]            prdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   // Pins and outputs
   input wire logic                   lra_mode_pin,
   input wire logic                   overdrive_active,
   input wire logic                   overdrive_gain_boost,
   input wire logic                   input_common_mode_bias,
   input wire logic                   drive_tick,
   input wire logic                   backemf_sample,
   input wire logic [`HDC_PER_W-1:0]  drive_period
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0]             sh_r;
   logic [7:0]             idx;
   logic                   acc;
   logic                   wr1;
   logic                   mapd;
   logic [`HDC_PER_W-1:0]  per_exp;

   // Decode of the bus cycle
   assign idx  = paddr[9:2];
   assign acc  = psel && penable;
   assign mapd = idx inside {`HDC_IDX_CTL1, `HDC_IDX_CTL2, `HDC_IDX_STAT};
   assign wr1  = acc && pwrite && pready && idx == `HDC_IDX_CTL1;
   // Period expected from the shadow; pin assumed settled
   assign per_exp = lra_mode_pin ?
      `HDC_PER_W'(sh_r[4:0] * LRA_STEP_CYC + LRA_OFS_CYC) :
      `HDC_PER_W'(sh_r[4:0] * ERM_STEP_CYC + ERM_OFS_CYC);

   // Shadow copy, reserved bit never kept
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         sh_r <= `HDC_CTL1_RST;
      else if (wr1)
         sh_r <= pwdata[7:0] & `HDC_CTL1_WMASK;
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_boost_gain: assert property ($past(presetn) |->
      overdrive_gain_boost == ($past(sh_r[7]) && $past(overdrive_active)))
      else $error("boost output wrong");
   a_bias_drive: assert property ($past(presetn) |->
      input_common_mode_bias == $past(sh_r[5]))
      else $error("bias output wrong");
   a_ctl1_read: assert property (acc && !pwrite &&
      idx == `HDC_IDX_CTL1 |-> prdata == {24'h0, sh_r})
      else $error("control read wrong");
   a_period_load: assert property (wr1 |-> ##2
      drive_period == per_exp) else $error("period not loaded");
   a_pready_high: assert property (pready) else $error("pready low");
   a_err_unmapped: assert property (acc && !mapd |-> pslverr)
      else $error("no error on unmapped");
   a_err_phase: assert property (pslverr |-> acc && !mapd)
      else $error("stray error");
   a_pulse_once: assert property (drive_tick |=> !drive_tick)
      else $error("tick too long");
   a_pulse_excl: assert property (!(drive_tick && backemf_sample))
      else $error("both pulses");

   c_write: cover property (wr1);
   c_err: cover property (pslverr);
   c_tick: cover property (drive_tick);
   c_sample: cover property (backemf_sample);
endmodule

bind hdc_drive_ctrl hdc_drive_ctrl_assertions #(
   .LRA_STEP_CYC(LRA_STEP_CYC), .LRA_OFS_CYC(LRA_OFS_CYC),
   .ERM_STEP_CYC(ERM_STEP_CYC), .ERM_OFS_CYC(ERM_OFS_CYC)
) i_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .lra_mode_pin(lra_mode_pin),
   .overdrive_active(overdrive_active),
   .overdrive_gain_boost(overdrive_gain_boost),
   .input_common_mode_bias(input_common_mode_bias),
   .drive_tick(drive_tick), .backemf_sample(backemf_sample),
   .drive_period(drive_period)
);

`default_nettype wire

// ===== bench/hdc_drive_ctrl_tb.sv
`include "hdc_defs.svh"
`default_nettype none

// ======
// Bench top
// ======
module haptic_drive_control_register_tb_top
   import hdc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        pclk, presetn, psel, penable, pwrite;
   logic [9:0]  paddr;
   logic [31:0] pwdata, prdata, rd, ex;
   logic        pready, pslverr, er, lra, zc, od, boost, bias, tick, smp;
   logic [20:0] per;
   logic [7:0]  ctl2q;
   int          fails = 0, num_checks = 0, cyc = 0, n;

   // Small step counts keep the run short
   hdc_drive_ctrl #(.LRA_STEP_CYC(4), .LRA_OFS_CYC(10),
      .ERM_STEP_CYC(8), .ERM_OFS_CYC(20)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .lra_mode_pin(lra),
      .zero_cross_pin(zc), .overdrive_active(od),
      .overdrive_gain_boost(boost), .input_common_mode_bias(bias),
      .drive_tick(tick), .backemf_sample(smp), .drive_period(per),
      .drive_control_two_q(ctl2q));

   // Free running clock
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   // One bus transfer; holds until pready seen
   task automatic apb(input logic w, input logic [7:0] idx,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {idx, 2'b00};
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Cycles between two pulses of one output
   task automatic gap(input logic s, output int g);
      g = 0;
      while ((s ? smp : tick) !== 1'b1) @(negedge pclk);
      do begin
         @(negedge pclk);
         g++;
      end while ((s ? smp : tick) !== 1'b1);
      // Back on the rising edge so later stimulus stays edge aligned
      @(posedge pclk);
   endtask

   task automatic conclude();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Hang guard, well above the longest test
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         conclude();
      end
   end

   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, zc, od} = '0;
      paddr = '0;
      pwdata = '0;
      lra = 1'b1;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, `HDC_IDX_CTL1, 0);
      chk("ctl1_rst", rd, 32'h0000_0093);
      chk("bias_rst", bias, 0);
      chk("boost_idle", boost, 0);
      od <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("boost_od", boost, 1);
      apb(1, `HDC_IDX_CTL1, 32'h0000_00FF);
      apb(0, `HDC_IDX_CTL1, 0);
      chk("ctl1_rsvd", rd, 32'h0000_00BF);
      chk("bias_on", bias, 1);
      apb(1, `HDC_IDX_CTL1, 0);
      repeat (3) @(posedge pclk);
      chk("bias_off", bias, 0);
      chk("boost_off", boost, 0);
      od <= 1'b0;
      // Both field ends in both actuator modes
      for (int m = 0; m < 4; m++) begin
         lra <= !m[1];
         repeat (12) @(posedge pclk);
         apb(1, `HDC_IDX_CTL1, m[0] ? 32'h0000_001F : 32'h0000_0000);
         ex = m[1] ? (m[0] ? 31 : 0) * 8 + 20 : (m[0] ? 31 : 0) * 4 + 10;
         repeat (3) @(posedge pclk);
         chk("period", per, ex);
         gap(m[1], n);
         chk("pulse_gap", n, ex);
      end
      // Resonant tracking replaces the estimate
      lra <= 1'b1;
      repeat (12) @(posedge pclk);
      apb(1, `HDC_IDX_CTL1, 32'h0000_0013);
      repeat (3) @(posedge pclk);
      chk("period_est", per, 86);
      zc <= 1'b1;
      repeat (60) @(posedge pclk);
      zc <= 1'b0;
      repeat (10) @(posedge pclk);
      chk("period_track", per, 60);
      // Unmapped place answers with an error
      apb(0, 8'h20, 0);
      chk("unm_err", er, 1);
      chk("unm_data", rd, 0);
      // Second register reaches the engine; status ignores writes
      apb(0, `HDC_IDX_CTL2, 0);
      chk("ctl2_rst", rd, 32'h0000_00F5);
      chk("ctl2_q_rst", ctl2q, 8'hF5);
      apb(1, `HDC_IDX_CTL2, 32'h0000_005A);
      apb(0, `HDC_IDX_CTL2, 0);
      chk("ctl2_rd", rd, 32'h0000_005A);
      chk("ctl2_q", ctl2q, 8'h5A);
      apb(1, `HDC_IDX_STAT, 32'h0000_0000);
      chk("stat_wr_err", er, 0);
      apb(0, `HDC_IDX_STAT, 0);
      chk("status", rd, 32'hC000_003C);
      conclude();
   end
endmodule

`default_nettype wire
